// File: logic/timer_pkg.sv
/*
  constants shared by the timer channel block: register offsets, field
  positions, reset values, bus answers and the edge / level select codes.
  assumes a 32-bit axi4-lite register bus with byte-wide registers in the
  low bits of aligned words.
*/
package timer_pkg;
  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 6;
  localparam logic [5:0]  OFS_TIMER_CTRL = 6'h00;  // stop, clear, prescale, wrap flag
  localparam logic [5:0]  OFS_MOD_HIGH   = 6'h04;  // modulo value, high byte
  localparam logic [5:0]  OFS_MOD_LOW    = 6'h08;  // modulo value, low byte
  localparam logic [5:0]  OFS_CNT_HIGH   = 6'h0c;  // counter, high byte (read only)
  localparam logic [5:0]  OFS_CNT_LOW    = 6'h10;  // counter, low byte (read only)
  localparam logic [5:0]  OFS_CHAN_BASE  = 6'h14;  // channel 0 control
  localparam logic [5:0]  CHAN_STRIDE    = 6'h0c;  // distance between channels
  localparam logic [5:0]  SUB_CTRL       = 6'h00;  // channel control
  localparam logic [5:0]  SUB_HIGH       = 6'h04;  // channel_value_high
  localparam logic [5:0]  SUB_LOW        = 6'h08;  // channel_value_low
  localparam logic [5:0]  OFS_BREAK      = 6'h2c;  // debug break state

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned TC_WRAP_FLAG = 7;   // counter_wrap_flag
  localparam int unsigned TC_STOP      = 5;
  localparam int unsigned TC_CLEAR     = 4;   // write-only, reads zero
  localparam int unsigned TC_PS_MSB    = 2;
  localparam int unsigned CC_FLAG      = 7;   // channel_event_flag
  localparam int unsigned CC_BUF       = 5;   // buffered_mode_bit
  localparam int unsigned CC_MODE_A    = 4;   // mode_a_bit
  localparam int unsigned CC_ELS_HI    = 3;   // edge_level_select_hi
  localparam int unsigned CC_ELS_LO    = 2;   // edge_level_select_lo
  localparam int unsigned CC_TOV       = 1;   // toggle_on_wrap
  localparam int unsigned CC_MAX       = 0;   // force_full_duty
  localparam logic [7:0]  CC_MASK0     = 8'h3f;  // channel 0 writable bits
  localparam logic [7:0]  CC_MASK1     = 8'h1f;  // channel 1 has no buffered bit
  localparam int unsigned BRK_ACTIVE   = 0;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic        STOP_RESET   = 1'b1;
  localparam logic [2:0]  PS_NONE      = 3'h7;   // prescale code with no clock
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // edge select in capture mode, pin action in compare mode
  typedef enum logic [1:0] {
    ELS_OFF  = 2'b00,  // pin released / software compare
    ELS_RISE = 2'b01,  // rising edge / toggle
    ELS_FALL = 2'b10,  // falling edge / drive low
    ELS_BOTH = 2'b11   // either edge / drive high
  } els_e;
endpackage

// File: logic/timebase_if.sv
/*
  time base bundle between the channel block and its counter.
  assumes both ends run on mclk.
*/
interface timebase_if;
  logic [15:0] count;   // counter value
  logic        tick;    // one-cycle timer clock enable
  logic        wrap;    // counter reached modulo on this tick
  logic [2:0]  ps;      // prescale select
  logic        stop;    // hold counter and prescaler
  logic        clear;   // one-cycle clear of counter and prescaler
  logic [15:0] modulo;  // wrap value

  modport source (output count, tick, wrap, input ps, stop, clear, modulo);
  modport sink   (input count, tick, wrap, output ps, stop, clear, modulo);
endinterface

// File: logic/timebase.sv
/*
  prescaler and 16-bit modulo counter of the timer.
  assumes control comes from the channel block on the same clock.
*/
module timebase (
  input  wire logic    mclk,
  input  wire logic    rst_b,
  timebase_if.source   tb
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  pre;    // free prescaler
    logic [15:0] count;  // timer counter
  } state_s;

  state_s r;       // registered state
  state_s next_r;  // next state
  logic [6:0] mask;  // prescaler bits that must be all ones

  // tick every 2^ps bus clocks; the unused code never ticks
  assign mask    = 7'((8'h01 << tb.ps) - 8'h01);
  assign tb.tick = !tb.stop && (tb.ps != timer_pkg::PS_NONE) && ((r.pre & mask) == mask);
  assign tb.wrap = tb.tick && (r.count == tb.modulo);  // [RULE19]
  assign tb.count = r.count;

  // next state: a stop freezes both stages, so a break holds the count
  always_comb begin
    next_r = r;
    if (tb.clear) begin
      next_r = '0;
    end else if (!tb.stop) begin  // [RULE16]
      next_r.pre = r.pre + 7'h01;
      if (tb.wrap) begin
        next_r.count = '0;  // restart from zero at the next tick [RULE19]
      end else if (tb.tick) begin
        next_r.count = r.count + 16'h0001;
      end
    end
  end

  // registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// File: logic/edge_detect.sv
/*
  channel pin synchroniser and active edge detector.
  assumes the pin is asynchronous to mclk.
*/
module edge_detect (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             pin_in,
  input  wire timer_pkg::els_e  els,
  output logic                  edge_pulse
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic s1;  // first sync stage, read only by s2
    logic s2;  // second sync stage
    logic s3;  // previous synced level
  } state_s;

  state_s r;
  state_s next_r;
  logic   rise;
  logic   fall;

  assign rise = r.s2 && !r.s3;
  assign fall = !r.s2 && r.s3;

  // select the active edge
  always_comb begin
    case (els)
      timer_pkg::ELS_RISE: edge_pulse = rise;  // [RULE2]
      timer_pkg::ELS_FALL: edge_pulse = fall;  // [RULE2]
      timer_pkg::ELS_BOTH: edge_pulse = rise || fall;  // [RULE2]
      default:             edge_pulse = 1'b0;
    endcase
  end

  // shift the pin through the sync chain
  always_comb begin
    next_r    = r;
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// File: logic/timer_channels.sv
/*
  two-channel capture / compare / pwm block with its axi4-lite registers.
  assumes one clock mclk, an active-low asynchronous reset, and pins that
  are resolved outside from chan_pin_out and chan_pin_oe.
*/
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
// Summary of operation
// [RULE1] select 00 releases pin; mode-a picks preset
// [RULE2] capture on rising, falling or either edge
// [RULE3] compare toggles, clears or sets the pin
// [RULE4] unbuffered select 00 is software compare only
// [RULE5] reset clears edge / level select bits
// [RULE6] pin must be stable two clocks before capture
// [RULE7] toggle_on_wrap inverts pin on counter wrap
// [RULE8] toggle_on_wrap ignored in capture; reset clears
// [RULE9] wrap action beats compare action when coincident
// [RULE10] force_full_duty with toggle_on_wrap forces 100% duty
// [RULE11] force_full_duty change takes effect next period
// [RULE12] polarity one: full duty high; zero: low
// [RULE13] value pair holds capture or compare value
// [RULE14] high byte read blocks capture until low read
// [RULE15] high byte write blocks compare until low write
// [RULE16] counter stops during a debug break
// [RULE17] flag set on capture edge or compare match
// [RULE18] channel 0 buffered bit disables channel 1
// [RULE19] wrap at modulo sets flag, restarts from zero
// [RULE20] capture copies full count in the edge cycle
module timer_channels (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [5:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [5:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic [1:0]  chan_pin_in,
  output logic [1:0]       chan_pin_out,
  output logic [1:0]       chan_pin_oe
);
  localparam int unsigned NCH = 2;  // channels

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 aw_got;      // write address held
    logic [5:0]           waddr;       // held write address
    logic                 w_got;       // write data held
    logic [7:0]           wbyte;       // held write byte
    logic                 wlane;       // byte lane 0 enabled
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic                 stop;        // counter stop
    logic [2:0]           ps;          // prescale select
    logic                 clear;       // one-cycle counter clear
    logic                 wrap_flag;   // counter_wrap_flag
    logic                 wrap_armed;  // flag read while set
    logic [15:0]          modulo;
    logic                 brk;         // debug break active
    logic [NCH-1:0][7:0]  ctrl;        // channel control, flag bit kept apart
    logic [NCH-1:0]       flag;        // channel_event_flag
    logic [NCH-1:0]       armed;       // flag read while set
    logic [NCH-1:0][15:0] value;       // channel value pair
    logic [NCH-1:0]       cap_lock;    // capture blocked by high-byte read
    logic [NCH-1:0]       cmp_lock;    // compare blocked by high-byte write
    logic [NCH-1:0]       level;       // pin output level
    logic [NCH-1:0]       max_on;      // force_full_duty as applied this period
    logic [15:0]          buf_cmp;     // active buffered compare value
    logic                 buf_sel;     // last written buffer register
  } state_s;

  // value pair comes out of reset as zero; software must not rely on it
  localparam state_s RST_STATE = '{stop: timer_pkg::STOP_RESET,
                                   modulo: timer_pkg::MODULO_RESET,
                                   level: '1, default: '0};

  state_s                r;          // registered state
  state_s                next_r;     // next state
  timebase_if            tb ();      // counter bundle
  logic [NCH-1:0][7:0]   eff;        // control as it acts, after masking
  logic [NCH-1:0][1:0]   els;        // edge / level select per channel
  logic [NCH-1:0]        is_cap;     // input capture mode
  logic [NCH-1:0]        is_cmp;     // output compare / pwm mode
  logic [NCH-1:0]        edge_hit;   // active edge from the pin
  logic                  take_aw;    // address handshake this cycle
  logic                  take_w;     // data handshake this cycle
  logic                  do_wr;      // write performed this cycle
  logic                  do_rd;      // read performed this cycle
  logic [5:0]            wa;         // word address of the write
  logic [5:0]            ra;         // word address of the read
  logic [7:0]            wb;         // write byte
  logic                  wl;         // write lane 0 enabled

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // byte offset of a channel register
  function automatic logic [5:0] chan_ofs(input int c, input logic [5:0] sub);
    chan_ofs = 6'(timer_pkg::OFS_CHAN_BASE + 6'(c) * timer_pkg::CHAN_STRIDE + sub);
  endfunction

  // true for every printed or chosen register word
  function automatic logic mapped(input logic [5:0] a);
    mapped = (a <= timer_pkg::OFS_BREAK);
  endfunction

  // ----------------------------------------------------------------------
  // counter and pin edge detectors
  // ----------------------------------------------------------------------
  timebase u_timebase (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tb    (tb)
  );

  assign tb.ps     = r.ps;
  assign tb.stop   = r.stop || r.brk;  // [RULE16]
  assign tb.clear  = r.clear;
  assign tb.modulo = r.modulo;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      edge_detect u_edge (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .pin_in     (chan_pin_in[g]),
        .els        (timer_pkg::els_e'(els[g])),
        .edge_pulse (edge_hit[g])
      );
      // only compare modes drive the pin; capture and select 00 release it
      assign chan_pin_oe[g]  = is_cmp[g] && (els[g] != timer_pkg::ELS_OFF);  // [RULE1]
      assign chan_pin_out[g] = r.level[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // bus handshakes; a held channel waits until the answer is taken
  // ----------------------------------------------------------------------
  assign awready = !r.aw_got && !r.bvalid;
  assign wready  = !r.w_got && !r.bvalid;
  assign arready = !r.rvalid;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = {24'h000000, r.rdata};
  assign rresp   = r.rresp;

  assign take_aw = awvalid && awready;
  assign take_w  = wvalid && wready;
  assign do_wr   = (r.aw_got || take_aw) && (r.w_got || take_w);
  assign do_rd   = arvalid && arready;
  assign wa      = r.aw_got ? {r.waddr[5:2], 2'b00} : {awaddr[5:2], 2'b00};
  assign ra      = {araddr[5:2], 2'b00};
  assign wb      = r.w_got ? r.wbyte : wdata[7:0];
  assign wl      = r.w_got ? r.wlane : wstrb[0];

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  // channel 1 control is dead while channel 0 runs buffered
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      eff[c] = r.ctrl[c];
      if (c == 1 && r.ctrl[0][timer_pkg::CC_BUF]) begin
        eff[c] = 8'h00;  // [RULE18]
      end
      els[c]    = {eff[c][timer_pkg::CC_ELS_HI], eff[c][timer_pkg::CC_ELS_LO]};
      is_cmp[c] = eff[c][timer_pkg::CC_BUF] || eff[c][timer_pkg::CC_MODE_A];
      is_cap[c] = !is_cmp[c] && (els[c] != timer_pkg::ELS_OFF);
    end
  end

  // ----------------------------------------------------------------------
  // next state: bus effects first, then hardware events so that sets win
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] cmp_val;
    logic        match;
    logic        wrap_act;
    logic        full;
    cmp_val  = '0;
    match    = 1'b0;
    wrap_act = 1'b0;
    full     = 1'b0;
    next_r   = r;
    next_r.clear = 1'b0;

    // hold a lone address or data beat until its partner arrives
    if (take_aw && !do_wr) begin
      next_r.aw_got = 1'b1;
      next_r.waddr  = awaddr;
    end
    if (take_w && !do_wr) begin
      next_r.w_got = 1'b1;
      next_r.wbyte = wdata[7:0];
      next_r.wlane = wstrb[0];
    end
    if (bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end

    // register reads, with their arming and unlocking side effects
    if (do_rd) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = 8'h00;
      next_r.rresp  = mapped(ra) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      if (ra == timer_pkg::OFS_TIMER_CTRL) begin
        next_r.rdata = {r.wrap_flag, 1'b0, r.stop, 2'b00, r.ps};
        next_r.wrap_armed = r.wrap_flag;
      end
      if (ra == timer_pkg::OFS_MOD_HIGH) next_r.rdata = r.modulo[15:8];
      if (ra == timer_pkg::OFS_MOD_LOW)  next_r.rdata = r.modulo[7:0];
      if (ra == timer_pkg::OFS_CNT_HIGH) next_r.rdata = tb.count[15:8];
      if (ra == timer_pkg::OFS_CNT_LOW)  next_r.rdata = tb.count[7:0];
      if (ra == timer_pkg::OFS_BREAK)    next_r.rdata = {7'h00, r.brk};
      for (int c = 0; c < NCH; c++) begin
        if (ra == chan_ofs(c, timer_pkg::SUB_CTRL)) begin
          next_r.rdata = r.ctrl[c] | {r.flag[c], 7'h00};
          next_r.armed[c] = r.flag[c];
        end
        if (ra == chan_ofs(c, timer_pkg::SUB_HIGH)) begin
          next_r.rdata = r.value[c][15:8];
          if (is_cap[c]) next_r.cap_lock[c] = 1'b1;  // [RULE14]
        end
        if (ra == chan_ofs(c, timer_pkg::SUB_LOW)) begin
          next_r.rdata = r.value[c][7:0];
          next_r.cap_lock[c] = 1'b0;  // [RULE14]
        end
      end
    end

    // register writes; byte lane 0 carries every register
    if (do_wr) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = mapped(wa) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end
    if (do_wr && wl) begin
      if (wa == timer_pkg::OFS_TIMER_CTRL) begin
        next_r.stop  = wb[timer_pkg::TC_STOP];
        next_r.clear = wb[timer_pkg::TC_CLEAR];
        next_r.ps    = wb[timer_pkg::TC_PS_MSB:0];
        // writing zero clears only after a read saw the flag set
        if (!wb[timer_pkg::TC_WRAP_FLAG] && r.wrap_armed) next_r.wrap_flag = 1'b0;
        next_r.wrap_armed = 1'b0;
      end
      if (wa == timer_pkg::OFS_MOD_HIGH) next_r.modulo[15:8] = wb;
      if (wa == timer_pkg::OFS_MOD_LOW)  next_r.modulo[7:0]  = wb;
      if (wa == timer_pkg::OFS_BREAK)    next_r.brk = wb[timer_pkg::BRK_ACTIVE];  // [RULE16]
      for (int c = 0; c < NCH; c++) begin
        if (wa == chan_ofs(c, timer_pkg::SUB_CTRL) && eff[0][timer_pkg::CC_BUF] == 1'b0
            || wa == chan_ofs(c, timer_pkg::SUB_CTRL) && c == 0) begin  // [RULE18]
          next_r.ctrl[c] = wb & ((c == 0) ? timer_pkg::CC_MASK0 : timer_pkg::CC_MASK1);
          if (!wb[timer_pkg::CC_FLAG] && r.armed[c]) next_r.flag[c] = 1'b0;
          next_r.armed[c] = 1'b0;
        end
        if (wa == chan_ofs(c, timer_pkg::SUB_HIGH)) begin
          next_r.value[c][15:8] = wb;  // [RULE13]
          if (is_cmp[c]) next_r.cmp_lock[c] = 1'b1;  // [RULE15]
          next_r.buf_sel = 1'(c);
        end
        if (wa == chan_ofs(c, timer_pkg::SUB_LOW)) begin
          next_r.value[c][7:0] = wb;  // [RULE13]
          next_r.cmp_lock[c] = 1'b0;  // [RULE15]
          next_r.buf_sel = 1'(c);
        end
      end
    end

    // counter wrap: flag, and the buffered value moves in for the new period
    if (tb.wrap) begin
      next_r.wrap_flag = 1'b1;  // [RULE19]
    end
    if (!eff[0][timer_pkg::CC_BUF]) begin
      next_r.buf_cmp = r.value[0];
    end else if (tb.wrap) begin
      next_r.buf_cmp = r.value[r.buf_sel];
    end

    // per-channel capture, compare and pin action
    for (int c = 0; c < NCH; c++) begin
      cmp_val  = (c == 0 && eff[c][timer_pkg::CC_BUF]) ? r.buf_cmp : r.value[c];
      match    = is_cmp[c] && tb.tick && (tb.count == cmp_val) && !r.cmp_lock[c];  // [RULE15]
      // toggle_on_wrap only matters in compare modes
      wrap_act = is_cmp[c] && tb.wrap && eff[c][timer_pkg::CC_TOV];  // [RULE8]
      // polarity one unless the compare sets the pin
      full     = (els[c] != timer_pkg::ELS_BOTH);  // [RULE12]

      // capture is blocked by a stopped counter or a pending high read
      if (is_cap[c] && edge_hit[c]) begin
        next_r.flag[c] = 1'b1;  // [RULE17]
        if (!r.cap_lock[c] && !tb.stop) begin
          next_r.value[c] = tb.count;  // [RULE20] [RULE13]
        end
      end
      if (match) begin
        next_r.flag[c] = 1'b1;  // [RULE17] [RULE4]
      end

      // full duty request is sampled at a period boundary in compare modes, every cycle otherwise
      if (tb.wrap || !is_cmp[c]) begin
        next_r.max_on[c] = eff[c][timer_pkg::CC_MAX] && eff[c][timer_pkg::CC_TOV];  // [RULE11]
      end

      if (els[c] == timer_pkg::ELS_OFF) begin
        // preset level while the port owns the pin: 0 high, 1 low
        next_r.level[c] = !eff[c][timer_pkg::CC_MODE_A];  // [RULE1]
      end else if (is_cmp[c]) begin
        if (r.max_on[c] && eff[c][timer_pkg::CC_TOV]) begin
          next_r.level[c] = full;  // [RULE10] [RULE12]
        end else if (wrap_act) begin
          next_r.level[c] = !r.level[c];  // [RULE7] [RULE9]
        end else if (match) begin
          case (els[c])
            timer_pkg::ELS_RISE: next_r.level[c] = !r.level[c];  // [RULE3]
            timer_pkg::ELS_FALL: next_r.level[c] = 1'b0;  // [RULE3]
            timer_pkg::ELS_BOTH: next_r.level[c] = 1'b1;  // [RULE3]
            default:             next_r.level[c] = r.level[c];
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers; reset clears every select bit, so both pins start released
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= RST_STATE;  // [RULE5] [RULE8]
    end else begin
      r <= next_r;
    end
  end
endmodule

// File: sim/timer_channels_checker.sv
/* port assertions for the timer channel block.
   assumes it is bound onto timer_channels by the bench top */
module timer_channels_checker (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  chan_pin_out,
  input wire logic [1:0]  chan_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------------
  // pins after reset, answers held until taken
  // ----------------------------------------------------------------------
  sequence rd_taken;  // read address accepted at this edge
    arvalid && arready;
  endsequence
  reset_pin_a:
    assert property (!$past(rst_b) |-> chan_pin_oe == 2'h0) else $error("pin driven after reset");
  reset_level_a:
    assert property (!$past(rst_b) |-> chan_pin_out == 2'h3) else $error("preset not high");
  read_answer_a:
    assert property (rd_taken |=> rvalid) else $error("read answer late");
  read_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read dropped");
  read_upper_a:
    assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
  read_block_a:
    assert property (rvalid |-> !arready) else $error("read taken while busy");
  write_hold_a:
    assert property (bvalid && !bready |=> bvalid) else $error("write answer dropped");
  write_block_a:
    assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
endmodule

// File: sim/pin_source.sv
/* far-side model: an external driver on both channel pins.
   assumes the block synchronises the pins itself */
module pin_source (
  output logic [1:0] chan_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial chan_pin_in = 2'h0;  // low and stable long before capture is armed
  // new level, then held; no glitches, since capture counts every edge
  task automatic drive(input logic [1:0] level);
    chan_pin_in <= level;
  endtask
endmodule

// File: sim/timer_channels_tb_top.sv
/* self-checking bench for timer_channels: bus tasks and pin scenarios.
   assumes the checker and the pin model are compiled before it */
module timer_channels_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // stimulus and answers
  // ----------------------------------------------------------------------
  logic        mclk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_data;  // rd_data: last read answer
  logic [3:0]  wstrb = 4'h1;                   // low byte lane only
  logic [1:0]  bresp, rresp, rd_resp, chan_pin_in, chan_pin_out, chan_pin_oe;
  int          err_count = 0;
  int          samples_checked = 0;
  timer_channels dut (.mclk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .chan_pin_in, .chan_pin_out, .chan_pin_oe);
  pin_source pins (.chan_pin_in);
  initial forever #25 mclk = ~mclk;
  task automatic conclude();
    $display("compared %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  // handshakes are sampled at the falling edge, where they are settled
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    logic ka, kw, kb;
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
    for (n = 0; n < 20; n++) begin
      @(negedge mclk);
      {ka, kw, kb} = {awready, wready, bvalid};
      @(posedge mclk);
      if (ka) awvalid <= 1'h0;
      if (kw) wvalid <= 1'h0;
      if (kb) break;
    end
    bready <= 1'h0;
    if (n == 20) conclude_fail();
    @(negedge mclk);  // results settled
    chk(32'(bresp), 32'h0);
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    logic ka, kr;
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 20; n++) begin
      @(negedge mclk);
      {ka, kr, rd_data, rd_resp} = {arready, rvalid, rdata, rresp};
      @(posedge mclk);
      if (ka) arvalid <= 1'h0;
      if (kr) break;
    end
    rready <= 1'h0;
    if (n == 20) conclude_fail();
    @(negedge mclk);
  endtask
  task automatic conclude_fail();  // a wait ran out
    err_count++;
    conclude();
  endtask
  task automatic t_reset();
    chk(32'(chan_pin_oe), 32'h0);
    rd(6'h14);
    chk(rd_data, 32'h0);
    rd(6'h30);  // unmapped offset is refused
    chk(32'(rd_resp), 32'h2);
    wr(6'h14, 8'h10);  // mode a with select 00: preset low, still released
    chk(32'(chan_pin_out[0]), 32'h0);
    chk(32'(chan_pin_oe), 32'h0);
    $display("reset and preset test done");
  endtask
  task automatic t_capture();
    wr(6'h00, 8'h10);  // clear and run the counter
    wr(6'h14, 8'h04);  // rising edge capture
    pins.drive(2'h1);
    repeat (6) @(posedge mclk);
    rd(6'h14);
    chk(rd_data, 32'h84);
    $display("capture test done");
  endtask
  task automatic t_compare();
    int n;
    wr(6'h20, 8'h10);
    chk(32'(chan_pin_out[1]), 32'h0);
    wr(6'h24, 8'h00);
    wr(6'h28, 8'h80);
    wr(6'h00, 8'h10);  // match at count 0x0080 after the clear
    wr(6'h20, 8'h1c);  // unbuffered compare, set pin on match
    chk(32'(chan_pin_oe[1]), 32'h1);
    for (n = 0; n < 300 && chan_pin_out[1] !== 1'h1; n++) @(negedge mclk);
    chk(32'(chan_pin_out[1]), 32'h1);
    $display("compare test done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    t_reset();
    t_capture();
    t_compare();
    conclude();
  end
endmodule
bind timer_channels timer_channels_checker checker_i (.mclk, .rst_b, .awready, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .chan_pin_out, .chan_pin_oe);
